// [rtl/rsri_pkg.sv]
// How it works
// - Resets load documented reset values into registers.
// - Interrupt wake with global enable vectors.
// - Wake sets flags of the wake source.
// - Comparator wake sets peripheral flag bit six.
// - Brown-out reset clears power status bit zero.
// - Unimplemented bits always read as zero.
// - Timeout and powerdown bits follow the cause.
// - Power-on during brown-out applies power-on values.
// - Power-on indicator zero after power-on only.
package rsri_pkg;
  // ----------------------------------------
  // Register offsets (word index, byte = 4x)
  // ----------------------------------------
  localparam logic [7:0] REG_INDIRECT_DATA_PORT = 8'h00;
  localparam logic [7:0] REG_TMR = 8'h01;
  localparam logic [7:0] REG_PCL = 8'h02;
  localparam logic [7:0] REG_STAT = 8'h03;
  localparam logic [7:0] REG_FSR = 8'h04;
  localparam logic [7:0] REG_PA = 8'h05;
  localparam logic [7:0] REG_PB = 8'h06;
  localparam logic [7:0] REG_PCH = 8'h0a;
  localparam logic [7:0] REG_ICTL = 8'h0b;
  localparam logic [7:0] REG_PFLG = 8'h0c;
  localparam logic [7:0] REG_CMP = 8'h1f;
  localparam logic [7:0] REG_OPT = 8'h81;
  localparam logic [7:0] REG_DIRA = 8'h85;
  localparam logic [7:0] REG_DIRB = 8'h86;
  localparam logic [7:0] REG_PEN = 8'h8c;
  localparam logic [7:0] REG_PWR = 8'h8e;
  localparam logic [7:0] REG_EE = 8'h90;
  localparam logic [7:0] REG_VREF = 8'h9f;
  localparam logic [7:0] REG_ACC = 8'hf0;
  localparam logic [7:0] REG_EVST = 8'hf1;
  localparam logic [7:0] REG_EVMSK = 8'hf2;
  localparam logic [7:0] REG_PCHI = 8'hf3;
  // ----------------------------------------
  // Masks and reset values
  // ----------------------------------------
  localparam logic [7:0] MASK_5 = 8'h1f;
  localparam logic [7:0] MASK_6 = 8'h3f;
  localparam logic [7:0] MASK_PFLG = 8'h40;
  localparam logic [7:0] MASK_PWR = 8'h03;
  localparam logic [7:0] MASK_EE = 8'h07;
  localparam logic [7:0] MASK_VREF = 8'hef;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hff;
  localparam logic [7:0] STAT_UPPER = 8'he0;
  localparam logic [7:0] ICTL_KEEP = 8'hfe;
  localparam logic [12:0] PC_VECTOR = 13'h0004;
  localparam logic [12:0] PC_ZERO = 13'h0000;
  localparam int STAT_TO = 4;
  localparam int STAT_PD = 3;
  localparam int PWR_BOR = 0;
  localparam int PWR_POR = 1;
  localparam int ICTL_GIE = 7;
  localparam int PFLG_CMP = 6;
  localparam int STAT_HI = 5;
  localparam logic [7:0] ICTL_RST_KEEP = 8'h01;
  localparam logic [7:0] STAT_TOPD = 8'h18;
  localparam logic [1:0] TOPD_SET = 2'h3;
  localparam logic [1:0] TOPD_SLEEP = 2'h2;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam int EV_W = 7;

  typedef enum logic [2:0] {
    RSRI_NONE, RSRI_POR, RSRI_PIN_RUN, RSRI_PIN_SLEEP, RSRI_WDT, RSRI_BOR
  } rsri_cause_t;

  // Wake request: which flags to set in interrupt control and peripheral flags
  typedef struct packed {
    logic irq;
    logic wdt;
    logic [2:0] ictl_flags;
    logic cmp_change;
  } rsri_wake_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rsri_wb_req_t;
endpackage

// [rtl/rsri_regs.sv]
module rsri_regs (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Reset causes and wake events from the reset circuitry
  input wire rsri_pkg::rsri_cause_t cause_i,
  input wire logic cause_vld_i,
  input wire rsri_pkg::rsri_wake_t wake_i,
  input wire logic wake_vld_i,
  // Wishbone slave
  input wire rsri_pkg::rsri_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Program counter and interrupt
  output logic [12:0] pc_o,
  output logic irq_o
);
  import rsri_pkg::*;

  logic [7:0] acc_ff, tmr_ff, pcl_ff, stat_ff, fsr_ff, pa_ff, pb_ff, pch_ff;
  logic [7:0] ictl_ff, pflg_ff, cmp_ff, opt_ff, dira_ff, dirb_ff, pen_ff;
  logic [7:0] pwr_ff, vref_ff, pchi_ff;
  logic [EV_W-1:0] evst_ff, evmsk_ff, nxt_ev;
  logic [12:0] pc_ff;
  logic wb_ack_ff, irq_ff;
  logic [31:0] wb_dat_ff;
  logic req, wr, rd, rst_ev, por_ev, wk;
  logic [7:0] wdat, rdat;
  logic wr_acc;
  logic wr_tmr;
  logic wr_pcl;
  logic wr_stat;
  logic wr_fsr;
  logic wr_pa;
  logic wr_pb;
  logic wr_pch;
  logic wr_ictl;
  logic wr_pflg;
  logic wr_cmp;
  logic wr_opt;
  logic wr_dira;
  logic wr_dirb;
  logic wr_pen;
  logic wr_pwr;
  logic wr_vref;
  logic wr_evmsk;
  logic rd_evst;

  function automatic logic is_reg(input logic [9:0] a, input logic [7:0] r);
    return a[9:2] == r;
  endfunction

  assign req = wb_i.cyc && wb_i.stb && !wb_ack_ff;
  assign wr = req && wb_i.we && wb_i.sel[0];
  assign rd = req && !wb_i.we;
  assign wdat = wb_i.dat[7:0];
  // Power-on outranks brown-out at the source: cause carries one value
  assign rst_ev = cause_vld_i && cause_i != RSRI_NONE;
  assign por_ev = cause_vld_i && cause_i == RSRI_POR;
  assign wk = wake_vld_i && !rst_ev;

  // ----------------------------------------
  // Write strobes, one per writable register, plus the event status read strobe
  // ----------------------------------------
  // Indirect port writes land in the pointer: the two share storage
  assign wr_acc = wr && is_reg(wb_i.adr, REG_ACC);
  assign wr_tmr = wr && is_reg(wb_i.adr, REG_TMR);
  assign wr_pcl = wr && is_reg(wb_i.adr, REG_PCL);
  assign wr_stat = wr && is_reg(wb_i.adr, REG_STAT);
  assign wr_fsr = wr && (is_reg(wb_i.adr, REG_FSR) || is_reg(wb_i.adr, REG_INDIRECT_DATA_PORT));
  assign wr_pa = wr && is_reg(wb_i.adr, REG_PA);
  assign wr_pb = wr && is_reg(wb_i.adr, REG_PB);
  assign wr_pch = wr && is_reg(wb_i.adr, REG_PCH);
  assign wr_ictl = wr && is_reg(wb_i.adr, REG_ICTL);
  assign wr_pflg = wr && is_reg(wb_i.adr, REG_PFLG);
  assign wr_cmp = wr && is_reg(wb_i.adr, REG_CMP);
  assign wr_opt = wr && is_reg(wb_i.adr, REG_OPT);
  assign wr_dira = wr && is_reg(wb_i.adr, REG_DIRA);
  assign wr_dirb = wr && is_reg(wb_i.adr, REG_DIRB);
  assign wr_pen = wr && is_reg(wb_i.adr, REG_PEN);
  assign wr_pwr = wr && is_reg(wb_i.adr, REG_PWR);
  assign wr_vref = wr && is_reg(wb_i.adr, REG_VREF);
  assign wr_evmsk = wr && is_reg(wb_i.adr, REG_EVMSK);
  assign rd_evst = rd && is_reg(wb_i.adr, REG_EVST);

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= '0;
    end else begin
      wb_ack_ff <= req;
      wb_dat_ff <= rd ? {24'h000000, rdat} : '0;
    end
  end

  // ----------------------------------------
  // Read mux, unimplemented bits zero
  // ----------------------------------------
  always_comb begin
    rdat = RST_ZERO;
    unique case (wb_i.adr[9:2])
      REG_TMR: rdat = tmr_ff;
      REG_PCL: rdat = pcl_ff;
      REG_STAT: rdat = stat_ff;
      REG_FSR, REG_INDIRECT_DATA_PORT: rdat = fsr_ff;
      REG_PA: rdat = pa_ff & MASK_5;
      REG_PB: rdat = pb_ff;
      REG_PCH: rdat = pch_ff & MASK_5;
      REG_ICTL: rdat = ictl_ff;
      REG_PFLG: rdat = pflg_ff & MASK_PFLG;
      REG_CMP: rdat = cmp_ff & MASK_6;
      REG_OPT: rdat = opt_ff;
      REG_DIRA: rdat = dira_ff & MASK_5;
      REG_DIRB: rdat = dirb_ff;
      REG_PEN: rdat = pen_ff & MASK_PFLG;
      REG_PWR: rdat = pwr_ff & MASK_PWR;
      REG_EE: rdat = MASK_EE;
      REG_VREF: rdat = vref_ff & MASK_VREF;
      REG_ACC: rdat = acc_ff;
      REG_EVST: rdat = {1'b0, evst_ff};
      REG_EVMSK: rdat = {1'b0, evmsk_ff};
      REG_PCHI: rdat = {3'h0, pc_ff[12:8]};
      default: rdat = RST_ZERO;
    endcase
  end

  // ----------------------------------------
  // Registers kept across every cause reset, power-on included
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_ff <= RST_ZERO;
    end else if (wr_acc && !rst_ev) begin
      acc_ff <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_ff <= RST_ZERO;
    end else if (wr_tmr && !rst_ev) begin
      tmr_ff <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fsr_ff <= RST_ZERO;
    end else if (wr_fsr && !rst_ev) begin
      fsr_ff <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_ff <= RST_ZERO;
    end else if (wr_pa && !rst_ev) begin
      pa_ff <= wdat & MASK_5;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pb_ff <= RST_ZERO;
    end else if (wr_pb && !rst_ev) begin
      pb_ff <= wdat;
    end
  end

  // ----------------------------------------
  // Registers with a defined reset state
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pch_ff <= RST_ZERO;
    end else if (rst_ev) begin
      pch_ff <= RST_ZERO;
    end else if (wr_pch) begin
      pch_ff <= wdat & MASK_5;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_ff <= RST_ZERO;
    end else if (rst_ev) begin
      cmp_ff <= RST_ZERO;
    end else if (wr_cmp) begin
      cmp_ff <= wdat & MASK_6;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opt_ff <= RST_ONES;
    end else if (rst_ev) begin
      opt_ff <= RST_ONES;
    end else if (wr_opt) begin
      opt_ff <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dira_ff <= MASK_5;
    end else if (rst_ev) begin
      dira_ff <= MASK_5;
    end else if (wr_dira) begin
      dira_ff <= wdat & MASK_5;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dirb_ff <= RST_ONES;
    end else if (rst_ev) begin
      dirb_ff <= RST_ONES;
    end else if (wr_dirb) begin
      dirb_ff <= wdat;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pen_ff <= RST_ZERO;
    end else if (rst_ev) begin
      pen_ff <= RST_ZERO;
    end else if (wr_pen) begin
      pen_ff <= wdat & MASK_PFLG;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vref_ff <= RST_ZERO;
    end else if (rst_ev) begin
      vref_ff <= RST_ZERO;
    end else if (wr_vref) begin
      vref_ff <= wdat & MASK_VREF;
    end
  end

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_ff <= PC_ZERO;
    end else if (rst_ev) begin
      pc_ff <= PC_ZERO;
    end else if (wk) begin
      // Vector only when the wake came from an interrupt and GLOBAL_INTERRUPT_ENABLE is set
      pc_ff <= (wake_i.irq && ictl_ff[ICTL_GIE]) ? PC_VECTOR : 13'(pc_ff + PC_STEP);
    end else if (wr_pcl) begin
      pc_ff <= {pch_ff[4:0], wdat};
    end
  end
  assign pcl_ff = pc_ff[7:0];

  // ----------------------------------------
  // Interrupt control and peripheral flags
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ictl_ff <= RST_ZERO;
    end else if (rst_ev) begin
      // Only the low flag survives a reset that is not power-on
      ictl_ff <= ictl_ff & ICTL_RST_KEEP & {8{!por_ev}};
    end else if (wr_ictl) begin
      // Wake flags win over a same-cycle software write
      ictl_ff <= wdat | (wk ? {5'h00, wake_i.ictl_flags} : RST_ZERO);
    end else if (wk) begin
      ictl_ff <= ictl_ff | {5'h00, wake_i.ictl_flags};
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pflg_ff <= RST_ZERO;
    end else if (rst_ev) begin
      pflg_ff <= RST_ZERO;
    end else if (wr_pflg) begin
      pflg_ff <= (wdat & MASK_PFLG) | ((wk && wake_i.cmp_change) ? MASK_PFLG : RST_ZERO);
    end else if (wk && wake_i.cmp_change) begin
      pflg_ff[PFLG_CMP] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Status: timeout and powerdown indicators
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_ff <= STAT_TOPD;
    end else if (rst_ev) begin
      stat_ff[7:STAT_HI] <= '0;
      // Brown-out picks the power-on pattern for the two indicators
      unique case (cause_i)
        RSRI_POR: stat_ff[STAT_TO:STAT_PD] <= TOPD_SET;
        RSRI_PIN_SLEEP: stat_ff[STAT_TO:STAT_PD] <= TOPD_SLEEP;
        RSRI_WDT: stat_ff[STAT_TO] <= 1'b0;
        RSRI_BOR: stat_ff[STAT_TO:STAT_PD] <= TOPD_SET;
        default: stat_ff[STAT_TO:STAT_PD] <= stat_ff[STAT_TO:STAT_PD];
      endcase
    end else if (wk) begin
      stat_ff[STAT_PD] <= 1'b0;
      stat_ff[STAT_TO] <= !wake_i.wdt;
    end else if (wr_stat) begin
      stat_ff <= (wdat & ~STAT_TOPD) | (stat_ff & STAT_TOPD);
    end
  end

  // ----------------------------------------
  // Power status
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_ff <= RST_ZERO;
    end else if (por_ev) begin
      pwr_ff[PWR_POR] <= 1'b0;
    end else if (rst_ev && cause_i == RSRI_BOR) begin
      pwr_ff[PWR_BOR] <= 1'b0;
    end else if (wr_pwr) begin
      pwr_ff <= wdat & MASK_PWR;
    end
  end

  // ----------------------------------------
  // Event status, mask, interrupt
  // ----------------------------------------
  always_comb begin
    nxt_ev = '0;
    nxt_ev[0] = por_ev;
    nxt_ev[1] = rst_ev && cause_i == RSRI_BOR;
    nxt_ev[2] = rst_ev && cause_i == RSRI_WDT;
    nxt_ev[3] = rst_ev && (cause_i == RSRI_PIN_RUN || cause_i == RSRI_PIN_SLEEP);
    nxt_ev[4] = wk && wake_i.irq;
    nxt_ev[5] = wk && wake_i.wdt;
    nxt_ev[6] = wk && wake_i.cmp_change;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evst_ff <= '0;
    end else begin
      // New event wins over read-clear
      evst_ff <= (rd_evst ? {EV_W{1'b0}} : evst_ff) | nxt_ev;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evmsk_ff <= '0;
    end else if (wr_evmsk) begin
      evmsk_ff <= wdat[EV_W-1:0];
    end
  end

  // Registered so the level output never glitches on a read-clear
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evst_ff & evmsk_ff);
    end
  end

  assign pchi_ff = '0;
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign pc_o = pc_ff;
  assign irq_o = irq_ff;
endmodule // rsri_regs

// [sim/rsri_regs_monitor.sv]
module rsri_regs_monitor (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Causes, wakes and bus request
  input wire rsri_pkg::rsri_cause_t cause_i,
  input wire logic cause_vld_i,
  input wire rsri_pkg::rsri_wake_t wake_i,
  input wire logic wake_vld_i,
  input wire rsri_pkg::rsri_wb_req_t wb_i,
  // Watched outputs
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [12:0] pc_o,
  input wire logic irq_o
);
  import rsri_pkg::*;
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire rd = wb_ack_o && !wb_i.we;
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_answer: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_idle_noack: assert property (!wb_i.cyc |=> !wb_ack_o) else $error("stray ack");
  a_pc_cause: assert property (
    cause_vld_i && cause_i != RSRI_NONE |=> pc_o == PC_ZERO) else $error("pc not cleared");
  a_pc_wake: assert property (
    wake_vld_i && !cause_vld_i && (wake_i.irq || wake_i.wdt)
    |=> pc_o == PC_VECTOR || pc_o == $past(pc_o) + 13'h1) else $error("bad wake pc");
  a_upper_zero: assert property (rd |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper data set");
  a_dira_mask: assert property (
    rd && wb_i.adr == {REG_DIRA, 2'b00} |-> wb_dat_o[7:5] == 3'h0) else $error("dir bits");
  a_pwr_mask: assert property (
    rd && wb_i.adr == {REG_PWR, 2'b00} |-> wb_dat_o[7:2] == 6'h0) else $error("pwr bits");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wb_i.cyc) || $past(wb_i.cyc, 2)
    || $past(cause_vld_i) || $past(cause_vld_i, 2)) else $error("irq fell alone");
  c_evst_read: cover property (rd && wb_i.adr == {REG_EVST, 2'b00});
  c_irq_wake: cover property (wake_vld_i && wake_i.irq);
  c_irq_rise: cover property ($rose(irq_o));
endmodule // rsri_regs_monitor

bind rsri_regs rsri_regs_monitor u_mon (.clock_i, .nrst_i, .cause_i, .cause_vld_i,
  .wake_i, .wake_vld_i, .wb_i, .wb_dat_o, .wb_ack_o, .pc_o, .irq_o);

// [sim/tb_rsri_regs.sv]
module tb_rsri_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import rsri_pkg::*;
  // ----
  // Stimulus, scoreboard and tables
  // ----
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  rsri_cause_t cause_i = RSRI_NONE;
  logic cause_vld_i = 1'b0;
  rsri_wake_t wake_i = '0;
  logic wake_vld_i = 1'b0;
  rsri_wb_req_t wb_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [12:0] pc_o;
  logic irq_o;
  logic [15:0] exp_q[$];
  logic [15:0] ent;
  logic [7:0] s, f;
  logic [12:0] pc_exp;
  int error_cnt = 0;
  int tests_run = 0;
  logic [15:0] rst_tab[10] = '{{REG_OPT, 8'hff}, {REG_DIRA, 8'h1f}, {REG_DIRB, 8'hff},
    {REG_PCL, 8'h00}, {REG_CMP, 8'h00}, {REG_VREF, 8'h00}, {REG_PCH, 8'h00},
    {REG_PEN, 8'h00}, {REG_PFLG, 8'h00}, {REG_EE, 8'h07}};
  rsri_cause_t c_tab[5] = '{RSRI_PIN_RUN, RSRI_PIN_SLEEP, RSRI_WDT, RSRI_BOR, RSRI_POR};
  logic [7:0] st_hi[5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h18};
  logic [7:0] st_m[5] = '{8'he7, 8'hff, 8'hf7, 8'he7, 8'hf8};
  logic [7:0] pw_e[5] = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h00};
  logic [7:0] ev_b[5] = '{8'h08, 8'h08, 8'h04, 8'h02, 8'h01};

  rsri_regs u_dut (.clock_i, .nrst_i, .cause_i, .cause_vld_i, .wake_i, .wake_vld_i,
    .wb_i, .wb_dat_o, .wb_ack_o, .pc_o, .irq_o);

  initial forever #10 clock_i = ~clock_i;

  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", what, e, g);
    end
  endtask

  // Reads queue mask and value; the scoreboard compares on ack
  task automatic wb(logic we, logic [7:0] off, logic [7:0] d, logic [7:0] m, logic [7:0] e);
    int n;
    n = 0;
    if (!we) exp_q.push_back({m, e});
    wb_i <= '{1'b1, 1'b1, we, {off, 2'b00}, 4'h1, {24'h0, d}};
    do @(posedge clock_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) error_cnt++;
    wb_i <= '0;
    @(posedge clock_i);
  endtask

  task automatic pulse(logic wk, rsri_cause_t c, rsri_wake_t w);
    cause_i <= c;
    cause_vld_i <= !wk;
    wake_i <= w;
    wake_vld_i <= wk;
    @(posedge clock_i);
    cause_vld_i <= 1'b0;
    wake_vld_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock_i) begin
    if (wb_ack_o === 1'b1 && wb_i.we === 1'b0) begin
      ent = exp_q.pop_front();
      check("rdata", {24'h0, ent[7:0]}, wb_dat_o & {24'hffffff, ent[15:8]});
    end
  end

  // Generous bound: whole sequence is well under a thousand bus cycles
  initial begin
    #200us;
    error_cnt++;
    complete_run();
  end

  initial begin
    void'($urandom(95243));
    pc_exp = PC_ZERO;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    wb(0, REG_STAT, 0, 8'hf8, 8'h18);
    wb(0, REG_PWR, 0, 8'h02, 8'h00);
    foreach (rst_tab[i]) wb(0, rst_tab[i][15:8], 0, 8'hff, rst_tab[i][7:0]);
    wb(1, 8'h07, 8'hff, 0, 0);
    wb(0, 8'h07, 0, 8'hff, 8'h00);
    for (int k = 0; k < 3; k++) begin
      s = $urandom & 8'h07;
      f = (k == 0) ? 8'h00 : $urandom & 8'h07;
      wb(1, REG_ICTL, {k == 2, 7'h0}, 0, 0);
      wb(1, REG_PFLG, 8'h00, 0, 0);
      wb(1, REG_STAT, 8'he0 | s, 0, 0);
      pulse(1, RSRI_NONE, '{k > 0, k == 0, f[2:0], k == 1});
      pc_exp = (k == 2) ? PC_VECTOR : pc_exp + 13'h1;
      check("pc", pc_exp, pc_o);
      wb(0, REG_ICTL, 0, 8'hff, {k == 2, 4'h0, f[2:0]});
      wb(0, REG_PFLG, 0, 8'hff, {1'b0, k == 1, 6'h0});
      wb(0, REG_STAT, 0, 8'hff, 8'he0 | s | {3'h0, k > 0, 4'h0});
    end
    for (int k = 0; k < 5; k++) begin
      s = $urandom & 8'h07;
      f = $urandom;
      foreach (rst_tab[i]) wb(1, rst_tab[i][15:8], $urandom, 0, 0);
      wb(1, REG_FSR, f, 0, 0);
      wb(1, REG_PWR, 8'h03, 0, 0);
      wb(1, REG_STAT, 8'he0 | s, 0, 0);
      wb(1, REG_EVMSK, k[0] ? ev_b[k] : 8'h00, 0, 0);
      wb(0, REG_EVST, 0, 8'h00, 8'h00);
      pulse(0, c_tab[k], '0);
      check("pc", PC_ZERO, pc_o);
      check("irq", k[0], irq_o);
      wb(0, REG_EVST, 0, ev_b[k], ev_b[k]);
      @(posedge clock_i);
      check("irq", 0, irq_o);
      foreach (rst_tab[i]) wb(0, rst_tab[i][15:8], 0, 8'hff, rst_tab[i][7:0]);
      wb(0, REG_FSR, 0, (k == 4) ? 8'h00 : 8'hff, (k == 4) ? 8'h00 : f);
      wb(0, REG_STAT, 0, st_m[k], (st_hi[k] | s) & st_m[k]);
      wb(0, REG_PWR, 0, (k == 4) ? 8'h02 : 8'h03, pw_e[k]);
    end
    complete_run();
  end
endmodule // tb_rsri_regs
